// ==== pabs_bank.sv ====
// read-only bank of protection overrun and alarm status words
//
// Summary of operation
// [RQ1] Overrun bit goes to 1 on threshold crossing, not after the delay.
// [RQ2] Quality word sits just below each status word; 1 valid, 0 invalid.
// [RQ3] Bit 15 of each status word set means bits 0 to 14 invalid.
// [RQ4] Standard overrun word: long-time pickup at bit 0, bits 1-14 reserved.
// [RQ5] Advanced overrun word: fifteen protections mapped in order on bits 0-14.
// [RQ6] Extended word: ground fault bit 0, earth leakage bit 1, rest reserved.
// [RQ7] Pre-alarm and user alarm bits stay 1 while the alarm is active.
// [RQ8] Pre-alarm word: long-time, leakage, ground fault on bits 0-2.
// [RQ9] User alarm word: alarms 201 to 210 on bits 0-9, rest reserved.
// [RQ10] All words read-only 16-bit; writes ignored; reserved reads zero.
// [RQ11] Master checks quality word and bit 15 before trusting a bit; the master model passes answers on unchecked.
`timescale 1ns/1ps
`default_nettype none
module pabs_bank
  import pabs_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst,
  // protection logic sources, one per status word, asynchronous
  input  wire pabs_src_t std_ovr_src,
  input  wire pabs_src_t adv_ovr_src,
  input  wire pabs_src_t adv_ext_src,
  input  wire pabs_src_t prealarm_src,
  input  wire pabs_src_t user_alarm_src,
  // register access from the serial link handler
  input  wire pabs_req_t reg_req,
  output var  pabs_rsp_t reg_rsp
);

  localparam int unsigned SRC_W = $bits(pabs_src_t);
  localparam int unsigned ALL_W = SRC_W * PABS_NUM_WORDS;

  // true when bit b of word w carries a defined field; masks come from
  // the field positions so a moved field cannot leave a stale mask
  function automatic logic bit_used(input int unsigned w,
                                    input int unsigned b);
    case (w)
      PABS_W_STD: bit_used = (b == PABS_STD_LONG_TIME_BIT);
      // every bit up to load shedding on power is defined
      PABS_W_ADV: bit_used = (b <= PABS_ADV_SHED_P_BIT);
      PABS_W_EXT: bit_used = (b == PABS_EXT_GROUND_FAULT_BIT)
                          || (b == PABS_EXT_LEAKAGE_BIT);
      PABS_W_PRE: bit_used = (b == PABS_PRE_LONG_TIME_BIT)
                          || (b == PABS_PRE_LEAKAGE_BIT)
                          || (b == PABS_PRE_GROUND_BIT);
      // user alarms form one run starting at the first bit
      PABS_W_USR: bit_used = (b <= PABS_USR_LAST_BIT);
      default:    bit_used = 1'b0;
    endcase
  endfunction

  // defined-bit mask of one word; everything else reads zero
  function automatic logic [14:0] used_mask(input int unsigned w);
    used_mask = PABS_FIELD_RST;
    for (int unsigned b = 0; b < PABS_FIELD_W; b++) begin
      used_mask[b] = bit_used(w, b);
    end
  endfunction

  // true when the address falls in the populated part of the bank
  function automatic logic in_words(input logic [15:0] a);
    in_words = (a >= PABS_STD_OVR_QUAL_OFS) && (a <= PABS_USR_OFS);
  endfunction

  // true when the address falls in the reserved tail of the bank
  function automatic logic in_reserved(input logic [15:0] a);
    in_reserved = (a >= PABS_RSVD_FIRST_OFS) && (a <= PABS_RSVD_LAST_OFS);
  endfunction

  logic [ALL_W-1:0] src_all;
  logic [ALL_W-1:0] s2_all;
  logic [ALL_W-1:0] s3_all;
  logic [ALL_W-1:0] filt_r;
  logic [ALL_W-1:0] filt_nxt;

  // bundle the sources in word order
  assign src_all = {user_alarm_src, prealarm_src, adv_ext_src,
                    adv_ovr_src, std_ovr_src};

  // sources come from another domain, so pass three flops
  pabs_sync3 #(
    .WIDTH (ALL_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in (src_all),
    .stage2_r (s2_all),
    .stage3_r (s3_all)
  );

  // a change is taken once stages two and three agree; no time delay
  // beyond that, so a crossing shows before any trip timer ends [RQ1]
  assign filt_nxt = (s2_all & ~(s2_all ^ s3_all))
                  | (filt_r & (s2_all ^ s3_all));

  // filtered source levels; alarm bits follow the live level [RQ7]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      filt_r <= '0;
    end else begin
      filt_r <= filt_nxt;
    end
  end

  logic [15:0] stat_w [PABS_NUM_WORDS];
  logic [15:0] qual_w [PABS_NUM_WORDS];

  // build each status word and its quality companion
  genvar g;
  generate
    for (g = 0; g < PABS_NUM_WORDS; g++) begin : g_word
      localparam logic [14:0] USED = used_mask(g);
      pabs_src_t w;
      assign w = pabs_src_t'(filt_r[g*SRC_W +: SRC_W]);
      // bit positions follow the source bit order of each word
      // [RQ4] [RQ5] [RQ6] [RQ8] [RQ9]
      // reserved bits forced to zero [RQ10]
      assign stat_w[g] = {w.invalid, w.active & USED}; // [RQ3]
      // quality bit 15 marks the invalid flag itself as always valid
      assign qual_w[g] = {1'b1, w.valid & USED}; // [RQ2]
    end
  endgenerate

  logic [15:0] rel_addr;
  logic [3:0]  rel_idx;
  logic [15:0] rd_word;

  // offset from the first quality word
  assign rel_addr = reg_req.addr - PABS_STD_OVR_QUAL_OFS;
  assign rel_idx  = rel_addr[3:0];

  // even offsets hold quality, odd ones the status just above [RQ2]
  always_comb begin
    rd_word = PABS_DATA_RST;
    if (in_words(reg_req.addr)) begin
      if (rel_idx[0]) begin
        rd_word = stat_w[rel_idx[3:1]];
      end else begin
        rd_word = qual_w[rel_idx[3:1]];
      end
    end
  end

  pabs_rsp_t rsp_r;
  pabs_rsp_t rsp_nxt;

  // one answer per request, next cycle; writes change nothing [RQ10]
  always_comb begin
    rsp_nxt       = '0;
    rsp_nxt.valid = reg_req.req;
    if (reg_req.req) begin
      if (reg_req.write) begin
        // no storage is written; the link reports the refusal [RQ10]
        rsp_nxt.err  = 1'b1;
        rsp_nxt.data = PABS_DATA_RST;
      end else if (in_words(reg_req.addr)) begin
        rsp_nxt.data = rd_word;
      end else if (in_reserved(reg_req.addr)) begin
        rsp_nxt.data = PABS_DATA_RST; // reserved reads zero [RQ10]
      end else begin
        rsp_nxt.err  = 1'b1; // unmapped address
        rsp_nxt.data = PABS_DATA_RST;
      end
    end
  end

  // answer register; data stays until the next answer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= rsp_nxt.valid;
      if (rsp_nxt.valid) begin
        rsp_r.err  <= rsp_nxt.err;
        rsp_r.data <= rsp_nxt.data;
      end
    end
  end

  assign reg_rsp = rsp_r;

endmodule
`default_nettype wire

// ==== pabs_pkg.sv ====
// package: address map, field masks and carrier types of the alarm status bank
package pabs_pkg;

  // word geometry
  localparam int unsigned PABS_WORD_W     = 16;
  localparam int unsigned PABS_FIELD_W    = 15;
  localparam int unsigned PABS_NUM_WORDS  = 5;
  localparam int unsigned PABS_INVAL_BIT  = 15;

  // register offsets, one register per address
  localparam logic [15:0] PABS_STD_OVR_QUAL_OFS = 16'h7d0d;
  localparam logic [15:0] PABS_STD_OVR_OFS      = 16'h7d0e;
  localparam logic [15:0] PABS_ADV_OVR_QUAL_OFS = 16'h7d0f;
  localparam logic [15:0] PABS_ADV_OVR_OFS      = 16'h7d10;
  localparam logic [15:0] PABS_ADV_EXT_QUAL_OFS = 16'h7d11;
  localparam logic [15:0] PABS_ADV_EXT_OFS      = 16'h7d12;
  localparam logic [15:0] PABS_PRE_QUAL_OFS     = 16'h7d13;
  localparam logic [15:0] PABS_PRE_OFS          = 16'h7d14;
  localparam logic [15:0] PABS_USR_QUAL_OFS     = 16'h7d15;
  localparam logic [15:0] PABS_USR_OFS          = 16'h7d16;
  localparam logic [15:0] PABS_RSVD_FIRST_OFS   = 16'h7d17;
  localparam logic [15:0] PABS_RSVD_LAST_OFS    = 16'h7d1a;

  // word indices within the bank (quality at 2k, status at 2k+1)
  localparam int unsigned PABS_W_STD = 0;
  localparam int unsigned PABS_W_ADV = 1;
  localparam int unsigned PABS_W_EXT = 2;
  localparam int unsigned PABS_W_PRE = 3;
  localparam int unsigned PABS_W_USR = 4;

  // implemented bits of bits 0..14 in each word; the rest are reserved
  localparam logic [14:0] PABS_STD_MASK = 15'h0001;
  localparam logic [14:0] PABS_ADV_MASK = 15'h7fff;
  localparam logic [14:0] PABS_EXT_MASK = 15'h0003;
  localparam logic [14:0] PABS_PRE_MASK = 15'h0007;
  localparam logic [14:0] PABS_USR_MASK = 15'h03ff;

  // field positions
  localparam int unsigned PABS_STD_LONG_TIME_BIT    = 0;
  localparam int unsigned PABS_ADV_CUR_UNBAL_BIT    = 0;
  localparam int unsigned PABS_ADV_MAX_I1_BIT       = 1;
  localparam int unsigned PABS_ADV_MAX_I2_BIT       = 2;
  localparam int unsigned PABS_ADV_MAX_I3_BIT       = 3;
  localparam int unsigned PABS_ADV_MAX_IN_BIT       = 4;
  localparam int unsigned PABS_ADV_MIN_V_BIT        = 5;
  localparam int unsigned PABS_ADV_MAX_V_BIT        = 6;
  localparam int unsigned PABS_ADV_V_UNBAL_BIT      = 7;
  localparam int unsigned PABS_ADV_MAX_P_BIT        = 8;
  localparam int unsigned PABS_ADV_REV_P_BIT        = 9;
  localparam int unsigned PABS_ADV_MIN_F_BIT        = 10;
  localparam int unsigned PABS_ADV_MAX_F_BIT        = 11;
  localparam int unsigned PABS_ADV_ROTATION_BIT     = 12;
  localparam int unsigned PABS_ADV_SHED_I_BIT       = 13;
  localparam int unsigned PABS_ADV_SHED_P_BIT       = 14;
  localparam int unsigned PABS_EXT_GROUND_FAULT_BIT = 0;
  localparam int unsigned PABS_EXT_LEAKAGE_BIT      = 1;
  localparam int unsigned PABS_PRE_LONG_TIME_BIT    = 0;
  localparam int unsigned PABS_PRE_LEAKAGE_BIT      = 1;
  localparam int unsigned PABS_PRE_GROUND_BIT       = 2;
  localparam int unsigned PABS_USR_FIRST_BIT        = 0; // alarm 201
  localparam int unsigned PABS_USR_LAST_BIT         = 9; // alarm 210

  // reset values
  localparam logic [15:0] PABS_DATA_RST  = 16'h0000;
  localparam logic [14:0] PABS_FIELD_RST = 15'h0000;

  // one status word's live sources from the protection logic
  typedef struct packed {
    logic        invalid; // whole word not significant
    logic [14:0] valid;   // per-bit quality, 1 = valid
    logic [14:0] active;  // per-bit overrun or alarm level
  } pabs_src_t;

  // register access request from the serial link handler
  typedef struct packed {
    logic        req;   // one-cycle strobe
    logic        write; // 1 = write attempt
    logic [15:0] addr;
    logic [15:0] wdata;
  } pabs_req_t;

  // answer to one request
  typedef struct packed {
    logic        valid; // one-cycle strobe
    logic        err;   // write refused or address unmapped
    logic [15:0] data;
  } pabs_rsp_t;

endpackage

// ==== pabs_sync3.sv ====
// three-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module pabs_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // asynchronous levels
  input  wire logic [WIDTH-1:0] async_in,
  // stages two and three for agreement checks
  output logic      [WIDTH-1:0] stage2_r,
  output logic      [WIDTH-1:0] stage3_r
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second; no logic looks at it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r   <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      meta_r   <= async_in;
      stage2_r <= meta_r;
      stage3_r <= stage2_r;
    end
  end

endmodule
`default_nettype wire

// ==== pabs_master_mdl.sv ====
// serial master model for the alarm status bank
`timescale 1ns/1ps
`default_nettype none
module pabs_master_mdl
  import pabs_pkg::*;
(
  // clock
  input  wire logic        clk_sys,
  // command from the bench
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [15:0] ad,
  input  wire logic [15:0] wd,
  // bank side
  output var  pabs_req_t   reg_req,
  input  wire pabs_rsp_t   reg_rsp,
  output var  pabs_rsp_t   got
);
  // idle fields inverted so stale values never look live
  assign reg_req = go ? {1'b1, wr, ad, wd} : {1'b0, ~wr, ~ad, ~wd};
  // answer sampled at every edge; bench reads it after the answer edge
  always_ff @(posedge clk_sys) begin
    got <= reg_rsp;
  end
endmodule
`default_nettype wire

// ==== pabs_bank_chk.sv ====
// assertions on the alarm status bank ports
`timescale 1ns/1ps
`default_nettype none
module pabs_bank_chk
  import pabs_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst,
  // watched ports
  input  wire pabs_src_t std_ovr_src,
  input  wire pabs_src_t adv_ovr_src,
  input  wire pabs_src_t adv_ext_src,
  input  wire pabs_src_t prealarm_src,
  input  wire pabs_src_t user_alarm_src,
  input  wire pabs_req_t reg_req,
  input  wire pabs_rsp_t reg_rsp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // read strobe and address classes
  wire logic        rd = reg_req.req && !reg_req.write;
  wire logic [15:0] a = reg_req.addr;
  wire logic        rsv = a >= PABS_RSVD_FIRST_OFS && a <= PABS_RSVD_LAST_OFS;
  wire logic        qual = a[0] && a >= 16'h7d0d && a <= 16'h7d15;
  // cycles since the advanced source last moved, saturating at 7
  pabs_src_t  adv_prev_r;
  logic [2:0] adv_age_r;
  always_ff @(posedge clk_sys) begin
    adv_prev_r <= adv_ovr_src;
    if (rst || adv_ovr_src != adv_prev_r) begin
      adv_age_r <= 3'h0;
    end else if (adv_age_r != 3'h7) begin
      adv_age_r <= adv_age_r + 3'h1;
    end
  end
  // a source settled past the synchroniser shows in the word as is
  adv_follow_a: assert property (
    rd && a == PABS_ADV_OVR_OFS && adv_age_r >= 3'h4 |=>
    reg_rsp.data == {$past(adv_ovr_src.invalid), $past(adv_ovr_src.active)})
    else $error("adv word not following source");
  // reserved bits of one status word stay clear
  property rsv_bits(logic [15:0] ofs, logic [14:0] m);
    rd && a == ofs |=> (reg_rsp.data[14:0] & ~m) == 15'h0000;
  endproperty
  ans_next_a: assert property (reg_req.req |=> reg_rsp.valid)
    else $error("no answer");
  wr_refuse_a: assert property (
    reg_req.req && reg_req.write |=> reg_rsp.err && reg_rsp.data == 16'h0)
    else $error("write not refused");
  rsv_zero_a: assert property (
    rd && rsv |=> !reg_rsp.err && reg_rsp.data == 16'h0)
    else $error("reserved word not zero");
  qual_top_a: assert property (rd && qual |=> reg_rsp.data[15])
    else $error("quality bit 15 clear");
  std_rsvd_a: assert property (
    rsv_bits(PABS_STD_OVR_OFS, PABS_STD_MASK)) else $error("std rsvd");
  ext_rsvd_a: assert property (
    rsv_bits(PABS_ADV_EXT_OFS, PABS_EXT_MASK)) else $error("ext rsvd");
  pre_rsvd_a: assert property (
    rsv_bits(PABS_PRE_OFS, PABS_PRE_MASK)) else $error("pre rsvd");
  usr_rsvd_a: assert property (
    rsv_bits(PABS_USR_OFS, PABS_USR_MASK)) else $error("usr rsvd");
  cover property (rd && qual);
  cover property (reg_req.req && reg_req.write);
  cover property (rd && rsv);
endmodule
bind pabs_bank pabs_bank_chk i_chk (
  .clk_sys(clk_sys), .rst(rst), .std_ovr_src(std_ovr_src),
  .adv_ovr_src(adv_ovr_src), .adv_ext_src(adv_ext_src),
  .prealarm_src(prealarm_src), .user_alarm_src(user_alarm_src),
  .reg_req(reg_req), .reg_rsp(reg_rsp));
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the alarm status bank
`timescale 1ns/1ps
`default_nettype none
module testbench import pabs_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        go = 1'b0, wr = 1'b0;
  logic [15:0] ad = 16'h0, wd = 16'h0;
  pabs_src_t   src [5];
  pabs_req_t   reg_req;
  pabs_rsp_t   reg_rsp, got;
  int          err_total = 0, samples_checked = 0;
  logic [14:0] msk [5] = '{PABS_STD_MASK, PABS_ADV_MASK, PABS_EXT_MASK,
                           PABS_PRE_MASK, PABS_USR_MASK};
  logic [15:0] far [4] = '{16'h7d0c, 16'h7d1b, 16'h0000, 16'hffff};
  always #2.5 clk_sys = ~clk_sys;
  pabs_bank i_pabs_bank (
    .clk_sys(clk_sys), .rst(rst), .std_ovr_src(src[0]),
    .adv_ovr_src(src[1]), .adv_ext_src(src[2]), .prealarm_src(src[3]),
    .user_alarm_src(src[4]), .reg_req(reg_req), .reg_rsp(reg_rsp));
  pabs_master_mdl i_pabs_master_mdl (
    .clk_sys(clk_sys), .go(go), .wr(wr), .ad(ad), .wd(wd),
    .reg_req(reg_req), .reg_rsp(reg_rsp), .got(got));
  // expected word: quality at odd offsets, status just above it
  function automatic logic [15:0] exp_w(logic [15:0] a);
    int k;
    k = int'(a - PABS_STD_OVR_QUAL_OFS) / 2;
    if (a > PABS_USR_OFS) return 16'h0000;
    if (a[0]) return {1'b1, src[k].valid & msk[k]};
    return {src[k].invalid, src[k].active & msk[k]};
  endfunction
  // one access; answer comes one edge after the request is taken
  task automatic acc(logic w, logic [15:0] a, logic e, logic [15:0] d);
    @(posedge clk_sys);
    go <= 1'b1; wr <= w; ad <= a; wd <= 16'($urandom);
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    samples_checked++;
    if (got !== {1'b1, e, d}) begin
      err_total++;
      $display("wrong value at %0t: addr %h got %h", $time, a, got);
    end
    // the answer strobe lasts one cycle only
    if (reg_rsp.valid !== 1'b0) begin
      err_total++;
      $display("wrong value at %0t: answer strobe held", $time);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    foreach (src[k]) src[k] = '0;
    void'($urandom(10169));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // pass 0 keeps reset levels, pass 1 sets all, then random
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys);
      for (int k = 0; k < 5; k++) begin
        if (i > 0) src[k] <= (i == 1) ? '1 : 31'($urandom);
      end
      repeat (6) @(posedge clk_sys);
      // quality word first, then its status word
      for (logic [15:0] a = 16'h7d0d; a <= 16'h7d1a; a++) begin
        acc(1'b1, a, 1'b1, 16'h0000);
        acc(1'b0, a, 1'b0, exp_w(a));
      end
    end
    foreach (far[j]) acc(1'b0, far[j], 1'b1, 16'h0000);
    end_of_test();
  end
  // run needs about 2200 cycles; stop a hang well past that
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
